// *** core/tsi_regs.svh ***
// register offsets, field positions, reset values of the interrupt unit
// assumes full avalon byte addresses, odd offsets included, 8-bit data in low lanes
`ifndef TSI_REGS_SVH
`define TSI_REGS_SVH
`define TSI_OFS_EDGE 8'hbf
`define TSI_OFS_FLAG 8'hc8
`define TSI_OFS_ENABLE 8'hc9
`define TSI_OFS_STACK 8'hdf
`define TSI_OFS_MASK 8'hca
`define TSI_BIT_EXT 0
`define TSI_BIT_TA 4
`define TSI_BIT_TB 5
`define TSI_BIT_GIE 7
`define TSI_BIT_TO 4
`define TSI_BIT_PD 3
`define TSI_EDGE_LO 3
`define TSI_EDGE_HI 4
`define TSI_EDGE_RST 2'h2
`define TSI_STACK_POINTER_REG_RST 2'h3
`define TSI_VECTOR 12'h008
`define TSI_SRC_MASK 8'h31
`endif

// *** core/tsi_pkg.sv ***
// types of the interrupt unit
// constants live in tsi_regs.svh
package tsi_pkg;
  typedef enum logic [1:0] {
    TSI_EDGE_RSVD,
    TSI_EDGE_RISE,
    TSI_EDGE_FALL,
    TSI_EDGE_BOTH
  } tsi_edge_t;
endpackage : tsi_pkg

// *** core/tsi_edge_det.sv ***
// external pin synchroniser and edge qualifier
// assumes pin is asynchronous to sys_clk_in
`timescale 1ns/100ps
module tsi_edge_det
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic pin_in,
  input wire logic [1:0] mode_in,
  output logic trig_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic last;
    logic trig;
  } tsi_edge_state_t;
  tsi_edge_state_t st_reg;
  tsi_edge_state_t st_next;

  always_comb
  begin
    st_next = st_reg;
    st_next.s1 = pin_in;
    st_next.s2 = st_reg.s1;
    st_next.last = st_reg.s2;
    unique case (tsi_pkg::tsi_edge_t'(mode_in))
      tsi_pkg::TSI_EDGE_RISE: st_next.trig = st_reg.s2 & ~st_reg.last;
      tsi_pkg::TSI_EDGE_FALL: st_next.trig = ~st_reg.s2 & st_reg.last;
      tsi_pkg::TSI_EDGE_BOTH: st_next.trig = st_reg.s2 ^ st_reg.last;
      tsi_pkg::TSI_EDGE_RSVD: st_next.trig = 1'b0;
    endcase
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign trig_out = st_reg.trig;
endmodule : tsi_edge_det

// *** core/tsi_irq_unit.sv ***
// three-source interrupt unit: flags, enables, global enable, context buffer
// assumes core gives one-cycle strobes for take/return/save/restore,
// timers give one-cycle overflow pulses on sys_clk_in
`timescale 1ns/100ps
`include "tsi_regs.svh"

// Operation
// - taken interrupt jumps to vector eight
// - save/restore accumulator and flags, one level
// - timeout and powerdown bits never saved/restored
// - pin trigger sets external flag always
// - external enable gates vector entry
// - edge field selects rise, fall, both
// - timer a overflow sets its flag
// - timer a enable gates vector entry
// - timer b overflow sets its flag
// - timer b enable gates vector entry
// - entry clears global enable, return sets
// - global enable required for vector entry, not for irq_out
// - flags cleared only by software
// - entry increments stack one level
module tsi_irq_unit
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic ext_irq_line_in,
  input wire logic timer_a_ovf_in,
  input wire logic timer_b_ovf_in,
  input wire logic take_ack_in,
  input wire logic return_from_irq_in,
  input wire logic ctx_save_in,
  input wire logic ctx_restore_in,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] program_flags_in,
  output logic irq_req_out,
  output logic vector_load_out,
  output logic [11:0] vector_addr_out,
  output logic [7:0] acc_restore_out,
  output logic [7:0] program_flags_restore_out,
  output logic restore_valid_out,
  output logic irq_out
);
  typedef struct packed {
    logic [1:0] edge_sel;
    logic ext_irq_flag;
    logic timer_a_irq_flag;
    logic timer_b_irq_flag;
    logic ext_irq_enable;
    logic timer_a_irq_enable;
    logic timer_b_irq_enable;
    logic global_irq_enable;
    logic [1:0] stack_ptr;
    logic [7:0] mask;
    logic [7:0] acc_buf;
    logic [7:0] flags_buf;
    logic buf_full;
    logic [7:0] acc_rst;
    logic [7:0] flags_rst;
    logic restore_valid;
    logic irq_req;
    logic vector_load;
    logic [11:0] vector_addr;
    logic bus_done;
    logic [31:0] rdata;
    logic irq;
  } tsi_state_t;

  tsi_state_t st_reg;
  tsi_state_t st_next;
  logic ext_trig;

  tsi_edge_det u_edge
  (
    .sys_clk_in(sys_clk_in),
    .reset_in(reset_in),
    .pin_in(ext_irq_line_in),
    .mode_in(st_reg.edge_sel),
    .trig_out(ext_trig)
  );

  // flag byte image in its register layout
  function automatic logic [7:0] src_byte(input logic e, input logic a, input logic b);
    logic [7:0] v;
    v = 8'h00;
    v[`TSI_BIT_EXT] = e;
    v[`TSI_BIT_TA] = a;
    v[`TSI_BIT_TB] = b;
    return v;
  endfunction : src_byte

  logic [7:0] flag_byte;
  logic [7:0] en_byte;
  logic [7:0] wbyte;
  logic wr_go;
  logic rd_go;
  logic pending;

  always_comb
  begin
    flag_byte = src_byte(st_reg.ext_irq_flag, st_reg.timer_a_irq_flag,
                         st_reg.timer_b_irq_flag);
    en_byte = src_byte(st_reg.ext_irq_enable, st_reg.timer_a_irq_enable,
                       st_reg.timer_b_irq_enable);
    wbyte = avs_writedata[7:0];
    // one wait state: a write lands on the edge that shows waitrequest low,
    // so the master never sees a write take effect before its answer
    wr_go = avs_write & st_reg.bus_done & avs_byteenable[0];
    rd_go = avs_read & ~st_reg.bus_done;
    pending = st_reg.global_irq_enable & (|(flag_byte & en_byte));
  end

  always_comb
  begin
    st_next = st_reg;
    st_next.bus_done = (avs_read | avs_write) & ~st_reg.bus_done;
    st_next.vector_load = 1'b0;
    st_next.restore_valid = 1'b0;

    // register writes
    if (wr_go)
    begin
      unique case (avs_address)
        `TSI_OFS_EDGE: st_next.edge_sel = wbyte[`TSI_EDGE_HI:`TSI_EDGE_LO];
        `TSI_OFS_FLAG:
        begin
          st_next.ext_irq_flag = wbyte[`TSI_BIT_EXT];
          st_next.timer_a_irq_flag = wbyte[`TSI_BIT_TA];
          st_next.timer_b_irq_flag = wbyte[`TSI_BIT_TB];
        end
        `TSI_OFS_ENABLE:
        begin
          st_next.ext_irq_enable = wbyte[`TSI_BIT_EXT];
          st_next.timer_a_irq_enable = wbyte[`TSI_BIT_TA];
          st_next.timer_b_irq_enable = wbyte[`TSI_BIT_TB];
        end
        `TSI_OFS_STACK:
        begin
          st_next.global_irq_enable = wbyte[`TSI_BIT_GIE];
          st_next.stack_ptr = wbyte[1:0];
        end
        `TSI_OFS_MASK: st_next.mask = wbyte & `TSI_SRC_MASK;
        default: ;
      endcase
    end

    if (ext_trig)
      st_next.ext_irq_flag = 1'b1;
    if (timer_a_ovf_in)
      st_next.timer_a_irq_flag = 1'b1;
    if (timer_b_ovf_in)
      st_next.timer_b_irq_flag = 1'b1;

    // request held while pending, dropped when core acknowledges entry
    st_next.irq_req = pending & ~take_ack_in;
    if (take_ack_in & st_reg.irq_req)
    begin
      st_next.global_irq_enable = 1'b0;
      st_next.stack_ptr = st_reg.stack_ptr + 2'h1;
      st_next.vector_load = 1'b1;
      st_next.vector_addr = `TSI_VECTOR;
    end
    else if (return_from_irq_in)
    begin
      st_next.global_irq_enable = 1'b1;
      st_next.stack_ptr = st_reg.stack_ptr - 2'h1;
    end

    // single buffer, a second save overwrites
    if (ctx_save_in)
    begin
      st_next.acc_buf = acc_in;
      // status bits left out of the buffer
      st_next.flags_buf = program_flags_in;
      st_next.flags_buf[`TSI_BIT_TO] = 1'b0;
      st_next.flags_buf[`TSI_BIT_PD] = 1'b0;
      st_next.buf_full = 1'b1;
    end
    else if (ctx_restore_in)
    begin
      st_next.acc_rst = st_reg.acc_buf;
      // live status bits pass through untouched
      st_next.flags_rst = st_reg.flags_buf;
      st_next.flags_rst[`TSI_BIT_TO] = program_flags_in[`TSI_BIT_TO];
      st_next.flags_rst[`TSI_BIT_PD] = program_flags_in[`TSI_BIT_PD];
      st_next.restore_valid = 1'b1;
      st_next.buf_full = 1'b0;
    end

    // read data registered at the answer edge
    if (rd_go)
    begin
      unique case (avs_address)
        `TSI_OFS_EDGE: st_next.rdata = {24'h0, 3'h0, st_reg.edge_sel, 3'h0};
        `TSI_OFS_FLAG: st_next.rdata = {24'h0, flag_byte};
        `TSI_OFS_ENABLE: st_next.rdata = {24'h0, en_byte};
        `TSI_OFS_STACK: st_next.rdata = {24'h0, st_reg.global_irq_enable, 5'h0,
                                         st_reg.stack_ptr};
        `TSI_OFS_MASK: st_next.rdata = {24'h0, st_reg.mask};
        default: st_next.rdata = 32'h0;
      endcase
    end

    // level output: any set flag whose mask bit is set
    st_next.irq = |(st_next.mask & src_byte(st_next.ext_irq_flag,
                    st_next.timer_a_irq_flag, st_next.timer_b_irq_flag));
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      st_reg <= '0;
      st_reg.edge_sel <= `TSI_EDGE_RST;
      st_reg.stack_ptr <= `TSI_STACK_POINTER_REG_RST;
      st_reg.vector_addr <= `TSI_VECTOR;
    end
    else
      st_reg <= st_next;
  end

  assign avs_readdata_out = st_reg.rdata;
  assign avs_waitrequest_out = ~st_reg.bus_done;
  assign irq_req_out = st_reg.irq_req;
  assign vector_load_out = st_reg.vector_load;
  assign vector_addr_out = st_reg.vector_addr;
  assign acc_restore_out = st_reg.acc_rst;
  assign program_flags_restore_out = st_reg.flags_rst;
  assign restore_valid_out = st_reg.restore_valid;
  assign irq_out = st_reg.irq;
endmodule : tsi_irq_unit

// *** bench/tsi_irq_checker_assertions.sv ***
// checker: timing relations at the interrupt unit ports
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
module tsi_irq_checker
(
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest_out,
  input wire logic take_ack_in,
  input wire logic ctx_restore_in,
  input wire logic irq_req_out,
  input wire logic vector_load_out,
  input wire logic [11:0] vector_addr_out,
  input wire logic restore_valid_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (reset_in);
  // ==========
  // assertions
  a_vector_eight: assert property (vector_load_out |-> vector_addr_out == 12'h008)
    else $error("vector address wrong");
  a_take_entry: assert property (irq_req_out && take_ack_in |=>
    vector_load_out && !irq_req_out) else $error("take did not enter vector");
  a_entry_cause: assert property (vector_load_out |-> $past(irq_req_out && take_ack_in))
    else $error("vector entry without request");
  a_single_entry: assert property (vector_load_out |=> !vector_load_out)
    else $error("vector entered twice");
  a_request_held: assert property (irq_req_out && !take_ack_in && !avs_write
    && !$past(avs_write) |=> irq_req_out) else $error("request dropped by itself");
  a_wait_once: assert property ($rose(avs_read || avs_write) |->
    avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("bus answer late");
  a_restore_pulse: assert property (ctx_restore_in |=> restore_valid_out)
    else $error("restore not answered");
  a_restore_cause: assert property (restore_valid_out |-> $past(ctx_restore_in))
    else $error("restore without request");
endmodule : tsi_irq_checker
bind tsi_irq_unit tsi_irq_checker u_chk (.*);

// *** bench/tsi_core_model.sv ***
// core model: takes the shared vector after a chosen delay
// assumes the unit drops its request the edge after the take strobe
`timescale 1ns/100ps
module tsi_core_model
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic irq_req_in,
  input wire logic [3:0] delay_in,
  output logic take_ack_out
);
  logic [3:0] wait_reg;
  // ==========
  // vector fetch, prompt or slow
  always_ff @(posedge clk_in)
  begin
    if (rst_in || !irq_req_in || take_ack_out)
    begin
      wait_reg <= 4'h0;
      take_ack_out <= 1'h0;
    end
    else
    begin
      wait_reg <= wait_reg + 4'h1;
      take_ack_out <= wait_reg == delay_in;
    end
  end
endmodule : tsi_core_model

// *** bench/three_source_interrupt_unit_tb.sv ***
// bench: scenarios for tsi_irq_unit against a core model
// assumes 200 MHz clock and 12-cycle synchronous reset
`timescale 1ns/100ps
`include "tsi_regs.svh"
module three_source_interrupt_unit_tb;
  logic sys_clk_in = 1'h0, reset_in = 1'h1, avs_read = 1'h0, avs_write = 1'h0, take_ack_in;
  logic ext_irq_line_in = 1'h0, timer_a_ovf_in = 1'h0, timer_b_ovf_in = 1'h0;
  logic return_from_irq_in = 1'h0, ctx_save_in = 1'h0, ctx_restore_in = 1'h0;
  logic avs_waitrequest_out, irq_req_out, irq_out, vector_load_out, restore_valid_out;
  logic [7:0] avs_address = 8'h0, acc_in = 8'h0, program_flags_in = 8'h0, acc_restore_out;
  logic [7:0] program_flags_restore_out, src [3] = '{8'h01, 8'h10, 8'h20};
  logic [31:0] avs_writedata = 32'h0, avs_readdata_out, q;
  logic [3:0] avs_byteenable = 4'hf, delay = 4'h0;
  logic [11:0] vector_addr_out;
  int num_errors = 0, checked = 0;
  always #2.5 sys_clk_in = ~sys_clk_in;
  tsi_irq_unit dut (.*);
  tsi_core_model core (.clk_in(sys_clk_in), .rst_in(reset_in), .irq_req_in(irq_req_out),
    .delay_in(delay), .take_ack_out(take_ack_in));
  // ==========
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_write <= wr;
    avs_read <= !wr;
    do
    begin
      @(posedge sys_clk_in);
      n++;
    end
    while (avs_waitrequest_out !== 1'h0 && n < 20);
    q = avs_readdata_out;
    avs_write <= 1'h0;
    avs_read <= 1'h0;
    @(posedge sys_clk_in);
    if (n >= 20)
      num_errors++;
  endtask : bus
  // pin toggles; timers get a one-cycle pulse
  task automatic fire(input int s);
    if (s == 0)
      ext_irq_line_in <= !ext_irq_line_in;
    else if (s == 1)
      timer_a_ovf_in <= 1'h1;
    else
      timer_b_ovf_in <= 1'h1;
    @(posedge sys_clk_in);
    timer_a_ovf_in <= 1'h0;
    timer_b_ovf_in <= 1'h0;
    repeat (8) @(posedge sys_clk_in);
  endtask : fire
  // ==========
  // scenarios
  task automatic t_reset();
    bus(0, `TSI_OFS_EDGE, 8'h0);
    check(q, 32'h10);
    bus(0, `TSI_OFS_STACK, 8'h0);
    check(q, 32'h03);
    bus(0, 8'h40, 8'h0);
    check(q, 32'h0);
  endtask : t_reset
  task automatic t_edges();
    for (int m = 0; m < 4; m++)
    begin
      bus(1, `TSI_OFS_EDGE, 8'(m << 3));
      for (int e = 0; e < 2; e++)
      begin
        fire(0);
        bus(0, `TSI_OFS_FLAG, 8'h0);
        check(q, {31'h0, ext_irq_line_in ? m[0] : m[1]});
        bus(1, `TSI_OFS_FLAG, 8'h0);
      end
    end
  endtask : t_edges
  task automatic t_gating();
    bus(1, `TSI_OFS_STACK, 8'h83);
    for (int s = 0; s < 3; s++)
      fire(s);
    check(irq_req_out, 1'h0);
    bus(0, `TSI_OFS_FLAG, 8'h0);
    check(q, 32'h31);
    bus(1, `TSI_OFS_MASK, 8'h20);
    repeat (2) @(posedge sys_clk_in);
    check(irq_out, 1'h1);
    bus(1, `TSI_OFS_MASK, 8'h0);
    repeat (2) @(posedge sys_clk_in);
    check(irq_out, 1'h0);
    // pulse lands on the edge that applies the clearing write
    fork
      bus(1, `TSI_OFS_FLAG, 8'h0);
      begin
        @(posedge sys_clk_in);
        timer_a_ovf_in <= 1'h1;
        @(posedge sys_clk_in);
        timer_a_ovf_in <= 1'h0;
      end
    join
    bus(0, `TSI_OFS_FLAG, 8'h0);
    check(q, 32'h10);
    bus(1, `TSI_OFS_FLAG, 8'h0);
  endtask : t_gating
  task automatic t_entry();
    for (int s = 0; s < 3; s++)
    begin
      delay <= 4'(s * 4);
      bus(1, `TSI_OFS_STACK, 8'h03);
      bus(1, `TSI_OFS_ENABLE, src[s]);
      fire(s);
      check(irq_req_out, 1'h0);
      bus(1, `TSI_OFS_STACK, 8'h83);
      for (int n = 0; n < 30 && vector_load_out !== 1'h1; n++)
        @(posedge sys_clk_in);
      check(vector_load_out, 1'h1);
      check(vector_addr_out, 12'h008);
      bus(0, `TSI_OFS_STACK, 8'h0);
      check(q, 32'h0);
      bus(0, `TSI_OFS_FLAG, 8'h0);
      check(q, {24'h0, src[s]});
      bus(1, `TSI_OFS_FLAG, 8'h0);
      return_from_irq_in <= 1'h1;
      @(posedge sys_clk_in);
      return_from_irq_in <= 1'h0;
      repeat (2) @(posedge sys_clk_in);
      bus(0, `TSI_OFS_STACK, 8'h0);
      check(q[7], 1'h1);
    end
  endtask : t_entry
  task automatic t_context();
    acc_in <= 8'h33;
    ctx_save_in <= 1'h1;
    @(posedge sys_clk_in);
    acc_in <= 8'h5a;
    program_flags_in <= 8'hff;
    @(posedge sys_clk_in);
    ctx_save_in <= 1'h0;
    acc_in <= 8'h0;
    program_flags_in <= 8'h08;
    ctx_restore_in <= 1'h1;
    @(posedge sys_clk_in);
    ctx_restore_in <= 1'h0;
    @(posedge sys_clk_in);
    check(acc_restore_out, 8'h5a);
    check(program_flags_restore_out, 8'hef);
  endtask : t_context
  task automatic results();
    if (num_errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results
  initial
  begin
    repeat (12) @(posedge sys_clk_in);
    reset_in <= 1'h0;
    @(posedge sys_clk_in);
    t_reset();
    t_edges();
    t_gating();
    t_entry();
    t_context();
    results();
  end
  initial
  begin
    #200000;
    num_errors++;
    results();
  end
endmodule : three_source_interrupt_unit_tb
